// ---- msrt_regs.svh ----
// Behaviour
// [RULE_01] vector mode branches to handler, saving and later restoring pc and status word
// [RULE_02] macro service moves data without software, pc and status word untouched
// [RULE_03] type A copies the receive data register into the buffer each request
// [RULE_04] after the programmed number of transfers an end interrupt is raised
// [RULE_05] after the end interrupt the source is back in vector mode
// [RULE_06] end interrupt uses the receive-complete vector entry, address 0022H
// [RULE_07] channel locator holds the low address byte of the transfer count location
// [RULE_08] count location defaults to FEBFH, loaded with fifteen transfers
// [RULE_09] service-mode bit set means macro service instead of vector dispatch
// [RULE_10] bit rate is count clock over (k+1), over tap n, over 16
// [RULE_11] transfer count decrements per transfer, end interrupt when it reaches zero
// [RULE_12] buffer destination advances one byte per transfer
`ifndef MSRT_REGS_SVH
`define MSRT_REGS_SVH

// fixed vector entry of the receive-complete request
`define MSRT_VEC_RX        16'h0022
// high byte of the on-chip ram page holding the count location
`define MSRT_CNT_PAGE      8'hFE
// reset values of the worked receive channel
`define MSRT_LOCATOR_RST   8'hBF
`define MSRT_COUNT_RST     8'h0F
`define MSRT_BUF_BASE_RST  16'hFEB0
// bit rate divider control fields
`define MSRT_DIV_K_MSB     3
`define MSRT_DIV_K_LSB     0
`define MSRT_DIV_TAP_MSB   6
`define MSRT_DIV_TAP_LSB   4
// oversampling ratio of the receiver
`define MSRT_OVERSAMPLE    5'h10

`endif

// ---- msrt_pkg.sv ----
package msrt_pkg;
    typedef logic [7:0]  msrt_byte_t;
    typedef logic [15:0] msrt_addr_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_VECT,
        ST_HANDLER
    } msrt_state_e;
endpackage

// ---- msrt_wr_if.sv ----
`timescale 1ns/1ns
interface msrt_wr_if;
    logic                valid;
    logic                ready;
    msrt_pkg::msrt_addr_t addr;
    msrt_pkg::msrt_byte_t data;
    modport src (output valid, output addr, output data, input ready);
    modport snk (input valid, input addr, input data, output ready);
endinterface

// ---- msrt_skid.sv ----
`timescale 1ns/1ns
// two-entry buffer: the spare slot holds a word while the sink stalls
module msrt_skid (
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    msrt_wr_if.snk                    in_if,
    output logic                      out_valid_o,
    output msrt_pkg::msrt_addr_t      out_addr_o,
    output msrt_pkg::msrt_byte_t      out_data_o,
    input  wire logic                 out_ready_i
);
    import msrt_pkg::*;

    logic       spare_valid_reg;
    msrt_addr_t spare_addr_reg;
    msrt_byte_t spare_data_reg;
    logic       push;
    logic       pop;

    // ready only reflects the spare slot, so it never depends on the sink combinationally
    assign in_if.ready = ~spare_valid_reg;
    assign push        = in_if.valid & ~spare_valid_reg;
    assign pop         = out_valid_o & out_ready_i;

    // head and spare slot movement
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_valid_o     <= 1'b0;
            out_addr_o      <= 16'h0000;
            out_data_o      <= 8'h00;
            spare_valid_reg <= 1'b0;
            spare_addr_reg  <= 16'h0000;
            spare_data_reg  <= 8'h00;
        end else if (!out_valid_o || pop) begin
            if (spare_valid_reg) begin
                out_valid_o     <= 1'b1;
                out_addr_o      <= spare_addr_reg;
                out_data_o      <= spare_data_reg;
                spare_valid_reg <= 1'b0;
            end else begin
                out_valid_o <= push;
                if (push) begin
                    out_addr_o <= in_if.addr;
                    out_data_o <= in_if.data;
                end
            end
        end else if (push) begin
            spare_valid_reg <= 1'b1;
            spare_addr_reg  <= in_if.addr;
            spare_data_reg  <= in_if.data;
        end
    end
endmodule // msrt_skid

// ---- msrt_service_unit.sv ----
`timescale 1ns/1ns
`include "msrt_regs.svh"
// interrupt service unit for the receive-complete source: vector or macro service
module msrt_service_unit (
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    // request from the receiver and its data register
    input  wire logic                 uart_receive_complete_request_i,
    input  wire msrt_pkg::msrt_byte_t rx_data_i,
    // software control of the channel
    input  wire logic                 service_mode_set_i,
    input  wire logic                 count_load_i,
    input  wire msrt_pkg::msrt_byte_t count_value_i,
    input  wire msrt_pkg::msrt_byte_t channel_locator_i,
    input  wire msrt_pkg::msrt_addr_t buffer_base_i,
    output logic                      service_mode_select_high_o,
    output msrt_pkg::msrt_byte_t      transfer_count_register_o,
    output msrt_pkg::msrt_addr_t      count_addr_o,
    // buffer write port
    output logic                      mem_wr_o,
    output msrt_pkg::msrt_addr_t      mem_addr_o,
    output msrt_pkg::msrt_byte_t      mem_data_o,
    input  wire logic                 mem_ready_i,
    // vector dispatch to the cpu core
    output logic                      vector_req_o,
    output msrt_pkg::msrt_addr_t      vector_addr_o,
    output logic                      end_service_o,
    input  wire logic                 vector_ack_i,
    input  wire msrt_pkg::msrt_addr_t cpu_pc_i,
    input  wire msrt_pkg::msrt_byte_t cpu_psw_i,
    input  wire logic                 return_i,
    output logic                      restore_o,
    output msrt_pkg::msrt_addr_t      restore_pc_o,
    output msrt_pkg::msrt_byte_t      restore_psw_o,
    // bit rate generator
    input  wire msrt_pkg::msrt_byte_t bit_rate_divider_control_i,
    output logic                      sample_tick_o,
    output logic                      bit_tick_o
);
    import msrt_pkg::*;

    msrt_state_e state_reg;
    logic        pending_reg;
    msrt_byte_t  rx_hold_reg;
    msrt_byte_t  count_reg;
    msrt_byte_t  locator_reg;
    msrt_addr_t  dest_reg;
    logic        mode_reg;
    msrt_addr_t  saved_pc_reg;
    msrt_byte_t  saved_psw_reg;
    logic        take;
    logic        xfer_done;
    logic        last_xfer;
    logic [3:0]  k_cnt_reg;
    logic [6:0]  n_cnt_reg;
    logic [3:0]  os_cnt_reg;
    logic [3:0]  div_k;
    logic [6:0]  div_n_last;

    msrt_wr_if wr ();

    // one request is taken from idle; decoding is shared by several processes
    assign take      = (state_reg == ST_IDLE) && pending_reg;
    assign xfer_done = (state_reg == ST_XFER) && wr.ready;
    assign last_xfer = xfer_done && (count_reg <= 8'h01);

    // request latch; a new request in the cycle it is taken keeps it pending
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pending_reg <= 1'b0;
        end else if (uart_receive_complete_request_i) begin
            pending_reg <= 1'b1;
        end else if (take) begin
            pending_reg <= 1'b0;
        end
    end

    // receive data register is sampled with its request
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_hold_reg <= 8'h00;
        end else if (uart_receive_complete_request_i) begin
            rx_hold_reg <= rx_data_i;
        end
    end

    // service mode bit: software sets it, the end of a block drops it
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= 1'b0;
        end else if (service_mode_set_i) begin
            mode_reg <= 1'b1;
        // [RULE_05] back to vector
        end else if (last_xfer) begin
            mode_reg <= 1'b0;
        end
    end

    // channel control data: count, locator and buffer pointer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // [RULE_08] worked channel defaults
            count_reg   <= `MSRT_COUNT_RST;
            locator_reg <= `MSRT_LOCATOR_RST;
            dest_reg    <= `MSRT_BUF_BASE_RST;
        end else if (count_load_i) begin
            count_reg   <= count_value_i;
            locator_reg <= channel_locator_i;
            dest_reg    <= buffer_base_i;
        end else if (xfer_done) begin
            // [RULE_11] count down per transfer
            count_reg <= (count_reg == 8'h00) ? 8'h00 : count_reg - 8'h01;
            // [RULE_12] next buffer byte
            dest_reg  <= dest_reg + 16'h0001;
        end
    end

    // [RULE_07] locator gives the count location
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_addr_o              <= {`MSRT_CNT_PAGE, `MSRT_LOCATOR_RST};
            transfer_count_register_o <= `MSRT_COUNT_RST;
            service_mode_select_high_o <= 1'b0;
        end else begin
            count_addr_o              <= {`MSRT_CNT_PAGE, locator_reg};
            transfer_count_register_o <= count_reg;
            service_mode_select_high_o <= mode_reg;
        end
    end

    // service sequencer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg     <= ST_IDLE;
            end_service_o <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // [RULE_09] mode bit picks macro service
                    if (take && mode_reg) begin
                        state_reg <= ST_XFER;
                    end else if (take) begin
                        state_reg     <= ST_VECT;
                        end_service_o <= 1'b0;
                    end
                end
                ST_XFER: begin
                    // [RULE_04] end interrupt after last
                    if (last_xfer) begin
                        state_reg     <= ST_VECT;
                        end_service_o <= 1'b1;
                    end else if (xfer_done) begin
                        // [RULE_02] no software involvement
                        state_reg <= ST_IDLE;
                    end
                end
                ST_VECT: begin
                    if (vector_ack_i) begin
                        state_reg <= ST_HANDLER;
                    end
                end
                default: begin
                    if (return_i) begin
                        state_reg     <= ST_IDLE;
                        end_service_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    // [RULE_03] receive data into buffer
    assign wr.valid = (state_reg == ST_XFER);
    assign wr.addr  = dest_reg;
    assign wr.data  = rx_hold_reg;

    // the buffer absorbs a stalled write so the next request is not held up at once
    msrt_skid u_skid (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .in_if       (wr),
        .out_valid_o (mem_wr_o),
        .out_addr_o  (mem_addr_o),
        .out_data_o  (mem_data_o),
        .out_ready_i (mem_ready_i)
    );

    // [RULE_06] fixed vector entry
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vector_req_o  <= 1'b0;
            vector_addr_o <= `MSRT_VEC_RX;
        end else begin
            vector_req_o  <= (take && !mode_reg) || last_xfer ||
                             ((state_reg == ST_VECT) && !vector_ack_i);
            vector_addr_o <= `MSRT_VEC_RX;
        end
    end

    // [RULE_01] save and restore context
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            saved_pc_reg  <= 16'h0000;
            saved_psw_reg <= 8'h00;
            restore_o     <= 1'b0;
            restore_pc_o  <= 16'h0000;
            restore_psw_o <= 8'h00;
        end else begin
            restore_o <= (state_reg == ST_HANDLER) && return_i;
            if ((state_reg == ST_VECT) && vector_ack_i) begin
                saved_pc_reg  <= cpu_pc_i;
                saved_psw_reg <= cpu_psw_i;
            end
            if ((state_reg == ST_HANDLER) && return_i) begin
                restore_pc_o  <= saved_pc_reg;
                restore_psw_o <= saved_psw_reg;
            end
        end
    end

    // [RULE_10] divisor fields of the control byte
    assign div_k      = bit_rate_divider_control_i[`MSRT_DIV_K_MSB:`MSRT_DIV_K_LSB];
    assign div_n_last = 7'(({4'h0, 3'h1} <<
                        bit_rate_divider_control_i[`MSRT_DIV_TAP_MSB:`MSRT_DIV_TAP_LSB]) - 7'h01);

    // [RULE_10] divide by k+1, tap n, then 16
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            k_cnt_reg     <= 4'h0;
            n_cnt_reg     <= 7'h00;
            os_cnt_reg    <= 4'h0;
            sample_tick_o <= 1'b0;
            bit_tick_o    <= 1'b0;
        end else begin
            sample_tick_o <= 1'b0;
            bit_tick_o    <= 1'b0;
            if (k_cnt_reg >= div_k) begin
                k_cnt_reg <= 4'h0;
                if (n_cnt_reg >= div_n_last) begin
                    n_cnt_reg     <= 7'h00;
                    sample_tick_o <= 1'b1;
                    os_cnt_reg    <= os_cnt_reg + 4'h1;
                    bit_tick_o    <= ({1'b0, os_cnt_reg} == `MSRT_OVERSAMPLE - 5'h01);
                end else begin
                    n_cnt_reg <= n_cnt_reg + 7'h01;
                end
            end else begin
                k_cnt_reg <= k_cnt_reg + 4'h1;
            end
        end
    end

    a_vec_entry_fixed: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_06]
        vector_req_o |-> vector_addr_o == `MSRT_VEC_RX)
        else $error("vector address is not the receive entry");

    a_mode_dispatch: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_09]
        (take && mode_reg) |=> (state_reg == ST_XFER) && !vector_req_o)
        else $error("macro service request was not transferred");

    a_data_capture: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_03]
        (uart_receive_complete_request_i && state_reg == ST_IDLE && !pending_reg
         && mode_reg && !count_load_i) |-> ##2 (wr.valid && wr.data == $past(rx_data_i, 2)))
        else $error("received byte not offered to buffer");

    a_count_step: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_11]
        (xfer_done && !count_load_i && count_reg != 8'h00)
        |=> count_reg == $past(count_reg) - 8'h01)
        else $error("transfer count did not step down");

    a_dest_step: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_12]
        (xfer_done && !count_load_i) |=> dest_reg == $past(dest_reg) + 16'h0001)
        else $error("buffer pointer did not advance");

    a_end_raised: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_04]
        last_xfer |=> vector_req_o && end_service_o)
        else $error("end interrupt missing after last transfer");

    a_end_vector_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_05]
        (last_xfer && !service_mode_set_i) |=> !mode_reg ##1 !service_mode_select_high_o)
        else $error("source not back in vector mode");

    a_macro_keeps_pc: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_02]
        (xfer_done && !last_xfer) |=> (!vector_req_o && !restore_o) [*2])
        else $error("macro transfer disturbed program flow");

    a_context_restore: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_01]
        ((state_reg == ST_VECT) && vector_ack_i) ##1 (return_i [*1])
        |=> restore_o && restore_pc_o == $past(cpu_pc_i, 2)
            && restore_psw_o == $past(cpu_psw_i, 2))
        else $error("saved context not restored");

    a_vector_dispatch: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_09]
        (take && !mode_reg) |=> vector_req_o && !end_service_o && !wr.valid)
        else $error("vector mode request did not reach the cpu");

    // the locator is registered twice on its way out, so the new location shows two edges on
    a_locator_addr: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_07]
        count_load_i |-> ##2 count_addr_o == {`MSRT_CNT_PAGE, $past(channel_locator_i, 2)})
        else $error("count location does not follow the locator");

    a_bit_on_sample: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_10]
        bit_tick_o |-> sample_tick_o)
        else $error("bit tick without a sample tick");
endmodule // msrt_service_unit

// ---- msrt_rx_model.sv ----
`timescale 1ns/1ns
// receiver stand-in: after a frame of bit ticks it raises one receive-complete request
module msrt_rx_model #(
    parameter int FRAME_BITS = 10
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 bit_tick_i,
    input  wire logic                 go_i,
    input  wire msrt_pkg::msrt_byte_t byte_i,
    output logic                      busy_o,
    output logic                      req_o,
    output msrt_pkg::msrt_byte_t      data_o
);
    import msrt_pkg::*;
    int         bits_seen;
    msrt_byte_t frame_reg;
    // frame length is counted in the unit's own bit ticks, so the divider sets the pace
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o    <= 1'b0;
            req_o     <= 1'b0;
            data_o    <= 8'h00;
            frame_reg <= 8'h00;
            bits_seen <= 0;
        end else begin
            req_o <= 1'b0;
            // outside the request cycle the data register is inverted every clock, so only the request cycle is sure to show the byte
            data_o <= ~data_o;
            if (go_i && !busy_o) begin
                busy_o    <= 1'b1;
                frame_reg <= byte_i;
                bits_seen <= 0;
            end else if (busy_o && bit_tick_i) begin
                bits_seen <= bits_seen + 1;
                if (bits_seen == FRAME_BITS - 1) begin
                    busy_o <= 1'b0;
                    req_o  <= 1'b1;
                    data_o <= frame_reg;
                end
            end
        end
    end
endmodule // msrt_rx_model

// ---- test_macro_service_receive_transfer.sv ----
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module test_macro_service_receive_transfer;
    import msrt_pkg::*;
    logic       mclk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       mode_set = 1'b0, cnt_load = 1'b0, mem_ready = 1'b1, ack = 1'b0, ret = 1'b0;
    msrt_byte_t cnt_val = 8'h00, locator = 8'h00, psw = 8'h00, brc = 8'h00, tx_byte = 8'h00;
    msrt_addr_t base = 16'h0000, pc = 16'h0000;
    logic       go = 1'b0;
    wire        req, busy, mode_o, mem_wr, vreq, end_svc, restore, s_tick, b_tick;
    msrt_byte_t rx_data, count_o, mem_data, rpsw;
    msrt_addr_t count_addr, mem_addr, vaddr, rpc;
    msrt_addr_t wr_addr_q[$];
    msrt_byte_t wr_data_q[$];
    int         bad_count = 0, checks_done = 0, cycles = 0;
    msrt_service_unit dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .uart_receive_complete_request_i(req), .rx_data_i(rx_data),
        .service_mode_set_i(mode_set), .count_load_i(cnt_load), .count_value_i(cnt_val),
        .channel_locator_i(locator), .buffer_base_i(base),
        .service_mode_select_high_o(mode_o), .transfer_count_register_o(count_o),
        .count_addr_o(count_addr), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr),
        .mem_data_o(mem_data), .mem_ready_i(mem_ready), .vector_req_o(vreq),
        .vector_addr_o(vaddr), .end_service_o(end_svc), .vector_ack_i(ack), .cpu_pc_i(pc),
        .cpu_psw_i(psw), .return_i(ret), .restore_o(restore), .restore_pc_o(rpc),
        .restore_psw_o(rpsw), .bit_rate_divider_control_i(brc), .sample_tick_o(s_tick),
        .bit_tick_o(b_tick));
    msrt_rx_model rx (.mclk_i(mclk_i), .rstn_i(rstn_i), .bit_tick_i(b_tick), .go_i(go),
        .byte_i(tx_byte), .busy_o(busy), .req_o(req), .data_o(rx_data));
    // 50 MHz clock
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    // buffer writes are logged at the edge where the sink accepts them
    always @(posedge mclk_i) begin
        if (mem_wr === 1'b1 && mem_ready === 1'b1) begin
            wr_addr_q.push_back(mem_addr);
            wr_data_q.push_back(mem_data);
        end
    end
    // hang guard: the whole sequence needs well under ten thousand cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // one received frame, then the request pulse from the receiver stand-in
    task automatic send(input msrt_byte_t b);
        @(posedge mclk_i);
        go      <= 1'b1;
        tx_byte <= b;
        @(posedge mclk_i);
        go <= 1'b0;
        settle(1);
        for (int i = 0; i < 400 && busy === 1'b1; i++) settle(1);
    endtask
    // cpu side of a vector: take it, return later, check the restored context
    task automatic service(input msrt_addr_t p, input msrt_byte_t s, input logic is_end);
        for (int i = 0; i < 20 && vreq !== 1'b1; i++) settle(1);
        `CHK("vector request", 1'b1, vreq)
        `CHK("vector address", 16'h0022, vaddr)
        `CHK("end of service flag", is_end, end_svc)
        @(posedge mclk_i);
        ack <= 1'b1;
        pc  <= p;
        psw <= s;
        // return right after the vector is taken, so the handler is entered and left at once
        @(posedge mclk_i);
        ack <= 1'b0;
        ret <= 1'b1;
        @(posedge mclk_i);
        ret <= 1'b0;
        settle(0);
        `CHK("vector dropped", 1'b0, vreq)
        for (int i = 0; i < 5 && restore !== 1'b1; i++) settle(1);
        `CHK("restore pulse", 1'b1, restore)
        `CHK("restored pc", p, rpc)
        `CHK("restored status", s, rpsw)
        settle(1);
        `CHK("end flag cleared", 1'b0, end_svc)
    endtask
    task automatic period_of(input logic bit_side, output int n);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                settle(1);
                n++;
            end while ((bit_side ? b_tick : s_tick) !== 1'b1 && n < 2000);
        end
    endtask
    initial begin
        int         per;
        msrt_byte_t ctl[3] = '{8'h00, 8'h12, 8'h2F};
        int         smp[3] = '{1, 6, 64};
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        settle(1);
        `CHK("count reset", 8'h0F, count_o)
        `CHK("count location reset", 16'hFEBF, count_addr)
        `CHK("mode reset", 1'b0, mode_o)
        $display("test reset values done");
        // vector mode: no buffer write, cpu gets a vector
        send(8'h11);
        service(16'h1234, 8'h5A, 1'b0);
        `CHK("writes in vector mode", 0, wr_addr_q.size())
        $display("test vector mode done");
        // macro service of three bytes, sink stalled for the first two
        @(posedge mclk_i);
        cnt_load  <= 1'b1;
        cnt_val   <= 8'h03;
        locator   <= 8'hC0;
        base      <= 16'hFE00;
        mem_ready <= 1'b0;
        @(posedge mclk_i);
        cnt_load <= 1'b0;
        mode_set <= 1'b1;
        @(posedge mclk_i);
        mode_set <= 1'b0;
        settle(3);
        `CHK("mode selected", 1'b1, mode_o)
        `CHK("count loaded", 8'h03, count_o)
        `CHK("count location", 16'hFEC0, count_addr)
        send(8'hA5);
        send(8'h5A);
        settle(8);
        `CHK("writes while stalled", 0, wr_addr_q.size())
        `CHK("no vector in macro mode", 1'b0, vreq)
        @(posedge mclk_i);
        mem_ready <= 1'b1;
        settle(8);
        `CHK("count after two", 8'h01, count_o)
        send(8'h3C);
        settle(8);
        `CHK("write count", 3, wr_addr_q.size())
        for (int i = 0; i < 3 && i < wr_addr_q.size(); i++) begin
            `CHK("buffer address", 16'hFE00 + 16'(i), wr_addr_q[i])
        end
        `CHK("first byte", 8'hA5, wr_data_q[0])
        `CHK("second byte", 8'h5A, wr_data_q[1])
        `CHK("third byte", 8'h3C, wr_data_q[2])
        `CHK("count at end", 8'h00, count_o)
        `CHK("mode cleared", 1'b0, mode_o)
        service(16'h4321, 8'hA1, 1'b1);
        // the source is back in vector mode: the next byte is not stored
        send(8'h77);
        service(16'h0F0F, 8'h3E, 1'b0);
        `CHK("no write after end", 3, wr_addr_q.size())
        $display("test macro service done");
        // bit rate: sample tick every (k+1)*2^n clocks for tap field n, bit tick every 16 of those
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            brc <= ctl[i];
            period_of(1'b0, per);
            `CHK("sample period", smp[i], per)
            period_of(1'b1, per);
            `CHK("bit period", smp[i] * 16, per)
        end
        $display("test bit rate done");
        end_sim();
    end
endmodule // test_macro_service_receive_transfer
